// ===== sam_consts.svh
`ifndef SAM_CONSTS_SVH
`define SAM_CONSTS_SVH

// Clock
`define SAM_CLK_NS        25

// Thresholds
`define SAM_TEMP_SET_C    8'h41
`define SAM_TEMP_CLR_C    8'h3C
`define SAM_SS_CAU_PCT    7'h1E
`define SAM_SS_ERR_PCT    7'h0F
`define SAM_SS_FULL_PCT   7'h64
`define SAM_SPEED_MAX     13'h1388

// Timing
`define SAM_DEB_NS        1000
`define SAM_DEB_CYC       ((`SAM_DEB_NS + `SAM_CLK_NS - 1) / `SAM_CLK_NS)
`define SAM_POWERON_MS    2000
`define SAM_FLASH_HALF_MS 250

// Register offsets
`define SAM_OFF_STATUS    8'h00
`define SAM_OFF_IRQ_STAT  8'h04
`define SAM_OFF_IRQ_CLR   8'h08
`define SAM_OFF_IRQ_EN    8'h0C
`define SAM_OFF_CTRL      8'h10
`define SAM_OFF_FLASH     8'h14

// Status fields
`define SAM_ST_ALM_LSB    0
`define SAM_ST_REG_LSB    8
`define SAM_ST_RED        10
`define SAM_ST_YEL        11
`define SAM_ST_PON        12

// Interrupt bits
`define SAM_IRQ_CAU_SET   0
`define SAM_IRQ_ERR_SET   1
`define SAM_IRQ_CAU_CLR   2

// Control bits
`define SAM_CTRL_ERRCLR   0

// Reset values
`define SAM_IRQ_EN_RST    3'h0

// Bus answers
`define SAM_RESP_OKAY     2'h0
`define SAM_RESP_SLVERR   2'h2

`endif

// ===== sam_pkg.sv
package sam_pkg;

  typedef enum logic [1:0] {
    SAM_REG_NORMAL  = 2'h0,
    SAM_REG_CAUTION = 2'h1,
    SAM_REG_ERROR   = 2'h2
  } sam_region_t;

  typedef enum logic [1:0] {
    SAM_LS_PON = 2'b01,
    SAM_LS_RUN = 2'b10
  } sam_led_st_t;

  // Register index; SAM_IX_NONE marks an unmapped address
  typedef enum logic [2:0] {
    SAM_IX_STATUS   = 3'h0,
    SAM_IX_IRQ_STAT = 3'h1,
    SAM_IX_IRQ_CLR  = 3'h2,
    SAM_IX_IRQ_EN   = 3'h3,
    SAM_IX_CTRL     = 3'h4,
    SAM_IX_FLASH    = 3'h5,
    SAM_IX_NONE     = 3'h7
  } sam_idx_t;

  typedef struct packed {
    logic signed [7:0] temp_c;
    logic [6:0]        ss_pct;
    logic [12:0]       speed_mm_s;
    logic              bal_fault;
    logic              abs_fault;
    logic              hw_fault;
    logic              init_fail;
  } sam_sense_t;

  // err: 0 strength, 1 balance, 2 absolute data, 3 hardware, 4 init, 5 overspeed
  typedef struct packed {
    logic [5:0] err;
    logic       ss_cau;
    logic       temp_cau;
  } sam_alarm_t;

  typedef struct packed {
    logic red;
    logic yellow;
  } sam_led_t;

endpackage

// ===== sam_debounce.sv
`timescale 1ns/1ps
`default_nettype none
`include "sam_consts.svh"

module sam_debounce (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic raw,
  output var  logic stable_ff
);

  logic [5:0] cnt_ff;

  // Output follows only after the input held steady for the whole window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff    <= 6'h0;
      stable_ff <= 1'b0;
    end else if (raw == stable_ff) begin
      cnt_ff <= 6'h0;
    end else if (cnt_ff == 6'(`SAM_DEB_CYC - 1)) begin
      cnt_ff    <= 6'h0;
      stable_ff <= raw;
    end else begin
      cnt_ff <= cnt_ff + 6'h1;
    end
  end

endmodule

`default_nettype wire

// ===== sam_alarm_led.sv
// Operation
// R1 - Alarms split into self-clearing cautions, held errors
// R2 - Errors stay set until clear or power-up
// R3 - Temperature caution above 65, clears below 60
// R4 - Strength caution below 30, clears above 30
// R5 - Strength error below 15 or at 100
// R6 - Held errors: balance, absolute data, hardware
// R7 - Held error when power-on initialization fails
// R8 - Held error when speed exceeds 5 m/s
// R9 - Strength regions normal, caution, error shown
// R10 - Solid red two seconds at power-on
// R11 - Caution plus error red; error only yellow
// R12 - Error-only yellow until far-end clear command
// R13 - Caution only flashes yellow, off when cleared
// R14 - Flash period and debounce are configurable constants
// R15 - Summary caution and error flags for link
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sam_consts.svh"

module sam_alarm_led
  import sam_pkg::*;
#(
  parameter int POWERON_CYC    = (`SAM_POWERON_MS * 1_000_000) / `SAM_CLK_NS,
  parameter int FLASH_HALF_CYC = (`SAM_FLASH_HALF_MS * 1_000_000) / `SAM_CLK_NS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire sam_sense_t  sense,
  input  wire logic        link_err_clr,
  output var  sam_alarm_t  alarm_ff,
  output var  sam_region_t region_ff,
  output var  sam_led_t    led_ff,
  output var  logic        caution_any_ff,
  output var  logic        error_any_ff,
  output var  logic        irq_ff,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int NRAW = 7;

  function automatic sam_idx_t reg_idx(input logic [7:0] addr);
    sam_idx_t ix;
    unique case (addr)
      `SAM_OFF_STATUS:   ix = SAM_IX_STATUS;
      `SAM_OFF_IRQ_STAT: ix = SAM_IX_IRQ_STAT;
      `SAM_OFF_IRQ_CLR:  ix = SAM_IX_IRQ_CLR;
      `SAM_OFF_IRQ_EN:   ix = SAM_IX_IRQ_EN;
      `SAM_OFF_CTRL:     ix = SAM_IX_CTRL;
      `SAM_OFF_FLASH:    ix = SAM_IX_FLASH;
      default:           ix = SAM_IX_NONE;
    endcase
    return ix;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic [NRAW-1:0] raw;
  logic [NRAW-1:0] deb;
  logic [5:0]      nxt_err;
  logic [5:0]      err_set;
  logic            nxt_temp_cau;
  logic            nxt_ss_cau;
  logic            err_clr;
  sam_region_t     nxt_region;
  sam_led_t        nxt_led;
  sam_led_st_t     led_st_ff;
  logic [26:0]     pon_cnt_ff;
  logic [23:0]     flash_cnt_ff;
  logic            flash_ff;
  logic [23:0]     flash_half_ff;
  logic [2:0]      irq_stat_ff;
  logic [2:0]      irq_en_ff;
  logic [2:0]      irq_ev;
  logic [2:0]      irq_clr;
  logic            aw_got_ff;
  logic            w_got_ff;
  logic [7:0]      awaddr_ff;
  logic [31:0]     wdata_ff;
  logic [3:0]      wstrb_ff;
  logic            wr_fire;
  sam_idx_t        wr_ix;
  sam_idx_t        rd_ix;
  logic [31:0]     rd_word;
  logic            sw_err_clr;
  logic [31:0]     en_merged;
  logic [31:0]     flash_merged;

  // Threshold comparisons, filtered against sensor noise
  assign raw[0] = sense.temp_c > $signed(`SAM_TEMP_SET_C);  // [R3]
  assign raw[1] = sense.temp_c < $signed(`SAM_TEMP_CLR_C);  // [R3]
  assign raw[2] = sense.ss_pct < `SAM_SS_CAU_PCT;           // [R4]
  assign raw[3] = sense.ss_pct > `SAM_SS_CAU_PCT;           // [R4]
  assign raw[4] = sense.ss_pct < `SAM_SS_ERR_PCT;           // [R5]
  assign raw[5] = sense.ss_pct >= `SAM_SS_FULL_PCT;         // [R5]
  assign raw[6] = sense.speed_mm_s > `SAM_SPEED_MAX;        // [R8]

  generate
    for (genvar g = 0; g < NRAW; g++) begin : gen_deb
      sam_debounce u_deb (  // [R14]
        .aclk      (aclk),
        .aresetn   (aresetn),
        .raw       (raw[g]),
        .stable_ff (deb[g])
      );
    end
  endgenerate

  // Cautions: hysteresis, between thresholds the flag holds
  always_comb begin
    nxt_temp_cau = alarm_ff.temp_cau;
    if (deb[0]) begin
      nxt_temp_cau = 1'b1;  // [R3] [R1]
    end else if (deb[1]) begin
      nxt_temp_cau = 1'b0;  // [R3] [R1]
    end
    nxt_ss_cau = alarm_ff.ss_cau;
    if (deb[2]) begin
      nxt_ss_cau = 1'b1;    // [R4] [R1]
    end else if (deb[3]) begin
      nxt_ss_cau = 1'b0;    // [R4] [R1]
    end
  end

  assign sw_err_clr = wr_fire && (wr_ix == SAM_IX_CTRL) && wstrb_ff[0]
                      && wdata_ff[`SAM_CTRL_ERRCLR];
  assign err_clr    = link_err_clr | sw_err_clr;  // [R12]

  assign err_set[0] = deb[4] | deb[5];     // [R5]
  assign err_set[1] = sense.bal_fault;     // [R6]
  assign err_set[2] = sense.abs_fault;     // [R6]
  assign err_set[3] = sense.hw_fault;      // [R6]
  assign err_set[4] = sense.init_fail;     // [R7]
  assign err_set[5] = deb[6];              // [R8]

  // A cause still present re-latches through a clear
  assign nxt_err = err_set | (alarm_ff.err & ~{6{err_clr}});  // [R2] [R1]

  always_comb begin
    if (deb[4] || deb[5]) begin
      nxt_region = SAM_REG_ERROR;    // [R9]
    end else if (nxt_ss_cau) begin
      nxt_region = SAM_REG_CAUTION;  // [R9]
    end else begin
      nxt_region = SAM_REG_NORMAL;   // [R9]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_ff       <= '0;
      region_ff      <= SAM_REG_NORMAL;
      caution_any_ff <= 1'b0;
      error_any_ff   <= 1'b0;
    end else begin
      alarm_ff.temp_cau <= nxt_temp_cau;
      alarm_ff.ss_cau   <= nxt_ss_cau;
      alarm_ff.err      <= nxt_err;                     // [R2]
      region_ff         <= nxt_region;                  // [R9]
      caution_any_ff    <= nxt_temp_cau | nxt_ss_cau;   // [R15]
      error_any_ff      <= |nxt_err;                    // [R15]
    end
  end

  // Indicator sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_st_ff  <= SAM_LS_PON;
      pon_cnt_ff <= 27'h0;
    end else begin
      unique case (led_st_ff)
        SAM_LS_PON: begin
          if (pon_cnt_ff == 27'(POWERON_CYC - 1)) begin
            led_st_ff <= SAM_LS_RUN;  // [R10]
          end else begin
            pon_cnt_ff <= pon_cnt_ff + 27'h1;
          end
        end
        SAM_LS_RUN: begin
          led_st_ff <= SAM_LS_RUN;
        end
        default: begin
          led_st_ff <= SAM_LS_PON;
        end
      endcase
    end
  end

  // Free-running blink; phase is not aligned to caution onset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_cnt_ff <= 24'h0;
      flash_ff     <= 1'b0;
    end else if (flash_cnt_ff + 24'h1 >= flash_half_ff) begin
      flash_cnt_ff <= 24'h0;
      flash_ff     <= ~flash_ff;  // [R13] [R14]
    end else begin
      flash_cnt_ff <= flash_cnt_ff + 24'h1;
    end
  end

  always_comb begin
    nxt_led = '0;
    if (led_st_ff != SAM_LS_RUN) begin
      nxt_led.red = 1'b1;  // [R10]
    end else begin
      unique case ({nxt_temp_cau | nxt_ss_cau, |nxt_err})
        2'b11:   nxt_led.red    = 1'b1;      // [R11]
        2'b01:   nxt_led.yellow = 1'b1;      // [R11] [R12]
        2'b10:   nxt_led.yellow = flash_ff;  // [R13]
        default: nxt_led        = '0;        // [R13] [R10]
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_ff <= '0;
    end else begin
      led_ff <= nxt_led;
    end
  end

  // Interrupt events
  assign irq_ev[`SAM_IRQ_CAU_SET] = (nxt_temp_cau | nxt_ss_cau) & ~caution_any_ff;
  assign irq_ev[`SAM_IRQ_ERR_SET] = |(nxt_err & ~alarm_ff.err);
  assign irq_ev[`SAM_IRQ_CAU_CLR] = ~(nxt_temp_cau | nxt_ss_cau) & caution_any_ff;
  assign irq_clr = (wr_fire && (wr_ix == SAM_IX_IRQ_CLR) && wstrb_ff[0])
                   ? wdata_ff[2:0] : 3'h0;

  // Event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= 3'h0;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= irq_ev | (irq_stat_ff & ~irq_clr);
      irq_ff      <= |((irq_ev | (irq_stat_ff & ~irq_clr)) & irq_en_ff);
    end
  end

  // Writable registers
  assign wr_ix   = reg_idx(awaddr_ff);
  assign wr_fire = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  assign en_merged    = merge_strb({29'h0, irq_en_ff}, wdata_ff, wstrb_ff);
  assign flash_merged = merge_strb({8'h0, flash_half_ff}, wdata_ff, wstrb_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_ff     <= `SAM_IRQ_EN_RST;
      flash_half_ff <= 24'(FLASH_HALF_CYC);  // [R14]
    end else if (wr_fire) begin
      if (wr_ix == SAM_IX_IRQ_EN) begin
        irq_en_ff <= en_merged[2:0];
      end
      if (wr_ix == SAM_IX_FLASH) begin
        flash_half_ff <= flash_merged[23:0];  // [R14]
      end
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      awaddr_ff     <= 8'h0;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SAM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff     <= 1'b1;
        awaddr_ff     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff     <= 1'b1;
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_ix == SAM_IX_NONE) ? `SAM_RESP_SLVERR
                                               : `SAM_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read mux; write-only registers read as zero
  assign rd_ix = reg_idx(s_axi_araddr);

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (rd_ix)
      SAM_IX_STATUS: begin
        rd_word[`SAM_ST_ALM_LSB +: 8] = alarm_ff;
        rd_word[`SAM_ST_REG_LSB +: 2] = region_ff;
        rd_word[`SAM_ST_RED]          = led_ff.red;
        rd_word[`SAM_ST_YEL]          = led_ff.yellow;
        rd_word[`SAM_ST_PON]          = led_st_ff == SAM_LS_PON;
      end
      SAM_IX_IRQ_STAT: rd_word[2:0]  = irq_stat_ff;
      SAM_IX_IRQ_EN:   rd_word[2:0]  = irq_en_ff;
      SAM_IX_FLASH:    rd_word[23:0] = flash_half_ff;
      default:         rd_word       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SAM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= (rd_ix == SAM_IX_NONE) ? `SAM_RESP_SLVERR
                                              : `SAM_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ===== sam_alarm_led_properties.sv
`timescale 1ns/1ps
`default_nettype none

module sam_alarm_led_chk
  import sam_pkg::*;
#(
  parameter int POWERON_CYC = 20
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire sam_sense_t  sense,
  input wire logic        link_err_clr,
  input wire sam_alarm_t  alarm_ff,
  input wire sam_region_t region_ff,
  input wire sam_led_t    led_ff,
  input wire logic        caution_any_ff,
  input wire logic        error_any_ff,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_awready
);
  // Cycles since reset release, saturating just past the power-on phase
  int   cnt_ff;
  logic idle;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 0;
    end else if (cnt_ff < POWERON_CYC + 3) begin
      cnt_ff <= cnt_ff + 1;
    end
  end

  assign idle = (cnt_ff == POWERON_CYC + 3);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pon_red_a: assert property (
    cnt_ff >= 2 && cnt_ff < POWERON_CYC |-> led_ff.red && !led_ff.yellow)
    else $error("power-on indicator not solid red");
  both_red_a: assert property (
    idle && caution_any_ff && error_any_ff |-> led_ff.red && !led_ff.yellow)
    else $error("caution plus error not red");
  err_yellow_a: assert property (
    idle && !caution_any_ff && error_any_ff |-> !led_ff.red && led_ff.yellow)
    else $error("error alone not solid yellow");
  cau_flash_a: assert property (
    idle && caution_any_ff && !error_any_ff |-> !led_ff.red)
    else $error("caution alone shows red");
  led_dark_a: assert property (
    idle && !caution_any_ff && !error_any_ff |-> !led_ff.red && !led_ff.yellow)
    else $error("indicator lit without alarm");
  summary_flags_a: assert property (
    caution_any_ff == (alarm_ff.ss_cau | alarm_ff.temp_cau)
    && error_any_ff == (|alarm_ff.err))
    else $error("summary flags disagree with alarms");
  err_hold_a: assert property (
    |($past(alarm_ff.err) & ~alarm_ff.err) |-> $past(link_err_clr) || $rose(s_axi_bvalid))
    else $error("error bit dropped without clear");
  hw_latch_a: assert property (sense.hw_fault |=> alarm_ff.err[3] && error_any_ff)
    else $error("hardware fault not latched");
  bal_latch_a: assert property (sense.bal_fault |=> alarm_ff.err[1])
    else $error("balance fault not latched");
  init_latch_a: assert property (sense.init_fail |=> alarm_ff.err[4])
    else $error("init failure not latched");
  region_err_a: assert property (region_ff == SAM_REG_ERROR |-> alarm_ff.err[0])
    else $error("error region without strength error");
  bresp_wait_a: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready)
    else $error("write address taken before response");
endmodule

bind sam_alarm_led sam_alarm_led_chk #(.POWERON_CYC(POWERON_CYC)) sam_alarm_led_chk_inst (
  .aclk, .aresetn, .sense, .link_err_clr, .alarm_ff, .region_ff, .led_ff,
  .caution_any_ff, .error_any_ff, .s_axi_bvalid, .s_axi_awready
);

`default_nettype wire

// ===== sam_servo_model.sv
`timescale 1ns/1ps
`default_nettype none

// Far-end amplifier: passes the bench request on as the clear, registered one cycle later
module sam_servo_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic req,
  output var  logic clr_ff
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_ff <= 1'h0;
    end else begin
      clr_ff <= req;
    end
  end
endmodule

`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sam_consts.svh"

module tb;
  import sam_pkg::*;
  localparam int PON = 20;
  logic        aclk, aresetn, link_err_clr, req, irq_ff, caution_any_ff, error_any_ff;
  sam_sense_t  sense;
  sam_alarm_t  alarm_ff;
  sam_region_t region_ff;
  sam_led_t    led_ff;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          err_count, samples_checked, cyc, tc, sc, er, ls, lv, nt;
  int tab[] = '{62,50,0,0, 60,50,0,0, 59,50,0,0, 65,50,0,0, 40,29,0,0, 40,30,0,0,
                40,31,0,0, 40,15,0,0, 40,14,0,0, 40,50,0,1, 40,100,0,1, 40,50,0,2,
                40,50,5000,0, 40,50,5001,1, 40,50,0,1};

  sam_alarm_led #(.POWERON_CYC(PON), .FLASH_HALF_CYC(4)) sam_alarm_led_inst (
    .aclk, .aresetn, .sense, .link_err_clr, .alarm_ff, .region_ff, .led_ff,
    .caution_any_ff, .error_any_ff, .irq_ff, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sam_servo_model sam_servo_model_inst (.aclk, .aresetn, .req, .clr_ff(link_err_clr));

  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task conclude;
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  task check;
    chk(alarm_ff, {er[5:0], sc[0], tc[0]});
    chk(error_any_ff, er != 0);
    chk(caution_any_ff, (sc | tc) != 0);
    if (ls != 30) chk(region_ff, (ls < 15 || ls >= 100) ? 2'h2 : ls < 30 ? 2'h1 : 2'h0);
    if ((sc | tc) == 0 || er != 0) begin
      chk(led_ff, ((sc | tc) != 0 && er != 0) ? 2'h2 : er != 0 ? 2'h1 : 2'h0);
    end else begin
      nt = 0;
      repeat (12) begin
        @(posedge aclk);
        nt += led_ff.yellow + 2 * led_ff.red;
      end
      chk(nt >= 4 && nt <= 8, 1'h1);
    end
    rd(`SAM_OFF_STATUS);
    chk(d[7:0], {er[5:0], sc[0], tc[0]});
  endtask

  task step(input int t, input int s, input int v);
    @(posedge aclk);
    sense.temp_c <= t[7:0];
    sense.ss_pct <= s[6:0];
    sense.speed_mm_s <= v[12:0];
    repeat (45) @(posedge aclk);
    ls = s;
    lv = v;
    if (t > 65) tc = 1; else if (t < 60) tc = 0;
    if (s < 30) sc = 1; else if (s > 30) sc = 0;
    if (s < 15 || s >= 100) er = er | 1;
    if (v > 5000) er = er | 32;
    check();
  endtask

  // Live causes survive a clear, so the model keeps only those
  task clear(input int k);
    if (k == 2) begin
      wr(`SAM_OFF_CTRL, 32'h1);
    end else begin
      @(posedge aclk);
      req <= 1'h1;
      @(posedge aclk);
      req <= 1'h0;
      repeat (3) @(posedge aclk);
    end
    er = ((ls < 15 || ls >= 100) ? 1 : 0) | (lv > 5000 ? 32 : 0);
    check();
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    void'($urandom(32'ha58d_0fe2));
    {aresetn, req, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    sense = '0;
    sense.ss_pct = 7'h32;
    {err_count, samples_checked, cyc, tc, sc, er, lv} = '0;
    ls = 50;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (5) @(posedge aclk);
    chk(led_ff, 2'h2);
    repeat (PON) @(posedge aclk);
    chk(led_ff, 2'h0);
    rd(`SAM_OFF_IRQ_EN);
    chk(d, 32'h0);
    rd(8'h20);
    chk({r, d}, {`SAM_RESP_SLVERR, 32'h0});
    wr(8'h20, 32'h0000_0001);
    chk(r, `SAM_RESP_SLVERR);
    rd(`SAM_OFF_FLASH);
    chk(d, 32'h0000_0004);
    s_axi_wstrb <= 4'h1;
    wr(`SAM_OFF_FLASH, 32'h0012_3406);
    s_axi_wstrb <= 4'hf;
    rd(`SAM_OFF_FLASH);
    chk(d, 32'h0000_0006);
    wr(`SAM_OFF_FLASH, 32'h0000_0004);
    chk(r, `SAM_RESP_OKAY);
    wr(`SAM_OFF_IRQ_EN, 32'h1);
    step(70, 50, 0);
    chk(irq_ff, 1'h1);
    $display("bus setup test done");
    for (int i = 0; i < $size(tab); i += 4) begin
      step(tab[i], tab[i+1], tab[i+2]);
      if (tab[i+3] != 0) clear(tab[i+3]);
    end
    $display("threshold table test done");
    repeat (10) step($urandom_range(75, 50), $urandom_range(99, 16), $urandom_range(5100, 0));
    step(40, 50, 0);
    clear(1);
    wr(`SAM_OFF_IRQ_CLR, 32'h7);
    wr(`SAM_OFF_IRQ_EN, 32'h2);
    chk(irq_ff, 1'h0);
    $display("random sweep test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      sense[3-i] <= 1'h1;
      @(posedge aclk);
      sense[3-i] <= 1'h0;
      @(posedge aclk);
      er = er | (2 << i);
      chk(alarm_ff.err, er[5:0]);
    end
    chk(irq_ff, 1'h1);
    rd(`SAM_OFF_IRQ_STAT);
    chk(d[1], 1'h1);
    wr(`SAM_OFF_IRQ_CLR, 32'h2);
    chk(irq_ff, 1'h0);
    step(70, 50, 0);
    chk(irq_ff, 1'h0);
    clear(2);
    step(50, 50, 0);
    rd(`SAM_OFF_IRQ_STAT);
    chk(d[2:0], 3'h5);
    $display("fault pulse test done");
    conclude();
  end
endmodule

`default_nettype wire
